/* dv/can_message_center_filter_tb.sv */
`timescale 1ns/1ps
module can_message_center_filter_tb;
  import cmcf_pkg::*;
  localparam logic [31:0] V = 32'h1 << C_VALID, DIR = 32'h1 << C_DIR, DU = 32'h1 << C_DU;
  localparam logic [31:0] TRQ = 32'h1 << C_TREQ, INT = 32'h1 << C_INTF, OWA = 32'h1 << C_OWA;
  localparam logic [31:0] RIE = 32'h1 << C_RIE, TIE = 32'h1 << C_TIE, ROW = 32'h1 << C_ROW;
  localparam logic [31:0] EXT = 32'h1 << C_EXT, IMU = 32'h1 << C_IMU, MMU = 32'h1 << C_MMU;
  // Every stored frame carries a length of eight
  localparam logic [31:0] RRS = 32'h1 << C_RRS, DL8 = 32'h8 << C_DLC;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd_q;
  logic pready, pslverr, serr, rx_valid, rx_error, rx_ext, rx_rtr, tx_valid, tx_ext;
  logic tx_ok, tx_lost, tx_err;
  logic [28:0] rx_id, tx_id;
  logic [3:0] rx_dlc, tx_dlc, tx_center;
  logic [63:0] rx_data, tx_data;
  int n_errors = 0, n_checks = 0, cyc = 0;

  always #12.5 clk = ~clk;

  cmcf_filter uut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_error(rx_error), .rx_ext(rx_ext), .rx_rtr(rx_rtr),
    .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_center(tx_center), .tx_ext(tx_ext), .tx_id(tx_id), .tx_dlc(tx_dlc),
    .tx_data(tx_data), .tx_ok(tx_ok), .tx_lost(tx_lost), .tx_err(tx_err));

  cmcf_bus_model bm (.clk(clk), .rstn(rstn), .rx_valid(rx_valid), .rx_error(rx_error),
    .rx_ext(rx_ext), .rx_rtr(rx_rtr), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_center(tx_center), .tx_ok(tx_ok), .tx_lost(tx_lost),
    .tx_err(tx_err));

  task automatic tally_and_finish;
    if (n_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Called just after a rising edge; pready is sampled as it stood at each edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never reassigns psel in this step
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    apb(1'b0, a, 32'h0);
    chk(rd_q & m, e);
  endtask

  function automatic logic [11:0] ctl(input int c);
    return 12'h040 + 12'(4 * (c - 1));
  endfunction

  function automatic logic [11:0] arb(input int c);
    return 12'h080 + 12'(4 * (c - 1));
  endfunction

  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(12'h000, 32'h7ff);
    rd(12'h018, 32'h0);
    chk({31'h0, serr}, 32'h1);
    wr(ctl(1), V | DIR);
    for (int c = 1; c <= 3; c++) wr(arb(c), 32'h123);
    wr(ctl(2), V | OWA | RIE);
    wr(ctl(3), V);
    bm.send(1'b0, 1'b1, 29'h123, 64'h0);
    rd(ctl(2), V | OWA | RIE);
    bm.send(1'b0, 1'b0, 29'h123, 64'h11);
    rd(ctl(2), V | OWA | RIE | DU | INT | DL8);
    bm.send(1'b0, 1'b0, 29'h123, 64'h22);
    rd(ctl(2), V | OWA | RIE | DU | INT | ROW | DL8);
    rd(12'h0c4, 32'h22);
    rd(ctl(3), V);
    rd(ctl(1), V | DIR);
    wr(12'h000, 32'h700);
    wr(arb(4), 32'h155);
    wr(ctl(4), V | IMU);
    bm.send(1'b0, 1'b0, 29'h1aa, 64'h0);
    rd(arb(4), 32'h1aa);
    // Media configured first so the extended frame proves bytes go unchecked
    wr(12'h008, 32'h5aa5);
    wr(12'h00c, 32'hffff);
    wr(arb(5), 32'h1abcdef0);
    wr(ctl(5), V | EXT);
    bm.send(1'b1, 1'b0, 29'h1abcdef0, 64'h0);
    rd(ctl(5), V | EXT | DU | DL8);
    wr(arb(6), 32'h300);
    wr(ctl(6), V | MMU);
    bm.send(1'b0, 1'b0, 29'h300, 64'h5a00);
    rd(ctl(6), V | MMU);
    bm.send(1'b0, 1'b0, 29'h300, 64'h5aa5);
    rd(ctl(6), V | MMU | DU | DL8);
    // Neither mask alone passes 0x0ff against id 0; only their AND does
    wr(12'h000, 32'h0f0);
    wr(12'h010, 32'h00f);
    wr(arb(15), 32'h0);
    wr(ctl(15), V | DIR | IMU);
    rd(ctl(15), V | IMU);
    bm.send(1'b0, 1'b0, 29'h0ff, 64'h0);
    rd(ctl(15), V | IMU | DU | DL8);
    bm.send(1'b0, 1'b0, 29'h0fe, 64'h0);
    rd(arb(15), 32'h0ff);
    rd(12'h014, 32'h100, 32'h100);
    wr(ctl(15), V | IMU | DU | OWA);
    bm.send(1'b0, 1'b0, 29'h0fd, 64'h0);
    rd(ctl(15), V | IMU | DU | OWA | ROW);
    wr(ctl(15), V | IMU);
    rd(arb(15), 32'h0fd);
    rd(12'h014, 32'h0, 32'h100);
    bm.send(1'b0, 1'b0, 29'h0fc, 64'h0);
    bm.send(1'b0, 1'b0, 29'h0fb, 64'h0);
    wr(ctl(15), V | IMU);
    rd(arb(15), 32'h0fc);
    // Remote frame holds the visible slot through its own seen bit
    wr(ctl(15), V | IMU);
    bm.send(1'b0, 1'b0, 29'h0fa, 64'h0, 1'b1);
    rd(ctl(15), V | IMU | RRS | DL8);
    bm.send(1'b0, 1'b0, 29'h0f9, 64'h0);
    wr(ctl(15), V | IMU | RRS);
    rd(arb(15), 32'h0fa);
    wr(ctl(15), V | IMU);
    rd(arb(15), 32'h0f9);
    bm.outcomes = '{1, 0, 0};
    wr(arb(8), 32'h222);
    wr(12'h0dc, 32'h0000beef);
    wr(ctl(8), V | DIR | DU | TRQ | TIE);
    repeat (5) @(posedge clk);
    chk({31'h0, tx_valid}, 32'h1);
    chk({28'h0, tx_center}, 32'd8);
    chk({3'h0, tx_id}, 32'h222);
    chk(tx_data[31:0], 32'h0000beef);
    chk({27'h0, tx_ext, tx_dlc}, 32'h0);
    wr(arb(7), 32'h111);
    wr(ctl(7), V | DIR | DU | TRQ | TIE);
    for (int i = 0; i < 500 && bm.seen.size() < 3; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk(32'(bm.seen.size()), 32'd3);
    chk({28'h0, bm.seen[0]}, 32'd8);
    chk({28'h0, bm.seen[1]}, 32'd7);
    chk({28'h0, bm.seen[2]}, 32'd8);
    rd(ctl(7), V | DIR | DU | TIE | INT);
    tally_and_finish();
  end
endmodule

/* dv/cmcf_bus_model.sv */
`timescale 1ns/1ps
module cmcf_bus_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Frames from the bus
  output logic rx_valid,
  output logic rx_error,
  output logic rx_ext,
  output logic rx_rtr,
  output logic [28:0] rx_id,
  output logic [3:0] rx_dlc,
  output logic [63:0] rx_data,
  // Transmit buffer
  input wire logic tx_valid,
  input wire logic [3:0] tx_center,
  output logic tx_ok,
  output logic tx_lost,
  output logic tx_err
);
  int delay = 20;
  int wait_n = 0;
  int o = 0;
  logic fire;
  logic pulsed = 1'b0;
  int outcomes[$];
  logic [3:0] seen[$];

  initial begin
    {rx_valid, rx_error, rx_ext, rx_rtr, rx_id, rx_dlc, rx_data} = '0;
    {tx_ok, tx_lost, tx_err} = '0;
  end

  task automatic send(input logic ext, input logic err, input logic [28:0] id,
                      input logic [63:0] d, input logic rtr = 1'b0);
    rx_valid <= 1'b1;
    rx_rtr <= rtr;
    rx_error <= err;
    rx_ext <= ext;
    rx_id <= id;
    rx_dlc <= 4'h8;
    rx_data <= d;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_rtr <= 1'b0;
    // Id and data invalid outside the pulse, so never hold the last value
    rx_id <= ~id;
    rx_data <= ~d;
    @(posedge clk);
  endtask

  // Answers each attempt once, after a slow arbitration delay
  always @(posedge clk) begin
    fire = 1'b0;
    if (rstn && tx_valid === 1'b1 && !pulsed) begin
      if (wait_n < delay) begin
        wait_n <= wait_n + 1;
      end else begin
        fire = 1'b1;
        o = (outcomes.size() > 0) ? outcomes.pop_front() : 0;
        seen.push_back(tx_center);
        wait_n <= 0;
      end
    end
    tx_ok <= fire && o == 0;
    tx_lost <= fire && o == 1;
    tx_err <= fire && o == 2;
    pulsed <= (tx_valid === 1'b1) && (pulsed || fire);
  end
endmodule

/* src/cmcf_filter.sv */
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Incoming frame tested on valid centers 1..15 in order; first pass takes it.
// [RULE2] Frames with bit errors, or matching no center, are dropped.
// [RULE3] Compare 29-bit or 11-bit identifier as the center's format selects.
// [RULE4] Id-mask-use applies standard or extended global mask per center format.
// [RULE5] Mask 1 compares a bit, mask 0 ignores it; no mask means exact.
// [RULE6] Media-mask-use checks first two data bytes under media masks.
// [RULE7] Without media-mask-use, data bytes are not tested.
// [RULE8] Center 15 ANDs its extra mask into the id mask only.
// [RULE9] Center 15 stores to visible slot if read, else to shadow buffer.
// [RULE10] Shadow moves to visible slot once data-updated and remote-seen both clear.
// [RULE11] A further message overwrites a waiting shadow message only if overwrite-allow is set; otherwise it is dropped.
// [RULE12] Software clears flag, data-updated and remote-seen after each center 15 read.
// [RULE13] Center 15 is receive-only; centers 1..14 send and receive.
// [RULE14] Transmit picks lowest center ready to send and loads the transmit buffer.
// [RULE15] Successful send clears that center's transmit request.
// [RULE16] After send, lost arbitration or error, the scan restarts from center 1.
// [RULE17] Data frames go only to receive-direction centers, lowest first.
// [RULE18] Overwrite-allow lets a full center be rewritten and flags overrun.
// [RULE19] Center 15 overrun reports shadow overwrite; bits show visible slot.
// [RULE20] Half-cleared center 15 keeps shadow; new messages to shadow or dropped.
// [RULE21] Center 15 catches messages no lower center accepted.
// [RULE22] Interrupt flag set on receive or send only if that enable is set.
// [RULE23] Acceptance completes and stores within the cycle the frame arrives.
module cmcf_filter
  import cmcf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Received frame from bit engine
  input wire logic rx_valid,
  input wire logic rx_error,
  input wire logic rx_ext,
  input wire logic rx_rtr,
  input wire logic [28:0] rx_id,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  // Transmit buffer to bit engine
  output logic tx_valid,
  output logic [3:0] tx_center,
  output logic tx_ext,
  output logic [28:0] tx_id,
  output logic [3:0] tx_dlc,
  output logic [63:0] tx_data,
  input wire logic tx_ok,
  input wire logic tx_lost,
  input wire logic tx_err
);
  import cmcf_pkg::*;

  typedef struct packed {
    logic [NUM_CENTERS-1:0][CW-1:0] ctrl;
    logic [NUM_CENTERS-1:0][28:0] arb;
    logic [NUM_CENTERS-1:0][63:0] data;
    logic [10:0] sgm;
    logic [28:0] egm;
    logic [15:0] mmatch;
    logic [15:0] mmask;
    logic [28:0] xmask;
    logic sh_valid;
    logic sh_rtr;
    logic [28:0] sh_id;
    logic [3:0] sh_dlc;
    logic [63:0] sh_data;
    logic tx_busy;
    logic [3:0] tx_idx;
    logic tx_ext;
    logic [28:0] tx_id;
    logic [3:0] tx_dlc;
    logic [63:0] tx_data;
    logic [3:0] last_rx;
    logic rdy;
    logic err;
    logic [31:0] rdata;
  } cmcf_state_s;

  cmcf_state_s q, n;
  logic [NUM_CENTERS-1:0] cand;
  logic [NUM_CENTERS-1:0] elig;
  logic [3:0] rx_pick;
  logic rx_hit;
  logic rx_take;
  logic [3:0] tx_pick;
  logic tx_done;
  logic [5:0] rsel;
  logic [3:0] wsel;
  logic cen_ok;
  logic apb_wr;
  logic [31:0] rd;
  logic bad;
  logic vis_free;
  logic [CW-1:0] cw;

  assign rsel = paddr[11:6];
  assign wsel = paddr[5:2];
  assign cen_ok = (wsel != 4'hf);
  assign tx_done = q.tx_busy && (tx_ok || tx_lost || tx_err);

  // Per-center acceptance and transmit readiness
  for (genvar g = 0; g < NUM_CENTERS; g++) begin : g_center
    logic ext;
    logic [28:0] gmask;
    logic [28:0] mask;
    logic [28:0] width;
    logic id_ok;
    logic media_ok;
    assign ext = q.ctrl[g][C_EXT];
    assign gmask = ext ? q.egm : {18'h0, q.sgm}; // RULE4
    if (g == LAST) begin : g_last
      assign mask = q.ctrl[g][C_IMU] ? (gmask & q.xmask) : MASK_RST; // RULE8
    end else begin : g_norm
      assign mask = q.ctrl[g][C_IMU] ? gmask : MASK_RST; // RULE5
    end
    assign width = ext ? 29'h1fffffff : 29'h000007ff; // RULE3
    assign id_ok = (rx_ext == ext) && (((rx_id ^ q.arb[g]) & mask & width) == 29'h0); // RULE5
    // Media bytes use only the shared media masks, never the extra mask
    assign media_ok = !q.ctrl[g][C_MMU] || // RULE7
      ((((rx_data[7:0] ^ q.mmatch[7:0]) & q.mmask[7:0]) == 8'h00) && // RULE6
       (((rx_data[15:8] ^ q.mmatch[15:8]) & q.mmask[15:8]) == 8'h00));
    assign cand[g] = q.ctrl[g][C_VALID] && !q.ctrl[g][C_DIR] && id_ok && media_ok; // RULE17
    if (g == LAST) begin : g_notx
      assign elig[g] = 1'b0; // RULE13
    end else begin : g_tx
      assign elig[g] = q.ctrl[g][C_DIR] && !q.ctrl[g][C_HOLD] && q.ctrl[g][C_DU] &&
        q.ctrl[g][C_VALID] && q.ctrl[g][C_TREQ]; // RULE14
    end
  end

  // Lowest-numbered candidate wins in both directions
  always_comb begin
    rx_pick = 4'h0;
    tx_pick = 4'h0;
    for (int i = NUM_CENTERS - 1; i >= 0; i--) begin
      if (cand[i]) begin
        rx_pick = 4'(i); // RULE1 RULE21
      end
      if (elig[i]) begin
        tx_pick = 4'(i); // RULE14
      end
    end
  end
  assign rx_hit = |cand;
  assign rx_take = rx_valid && !rx_error && rx_hit; // RULE2

  always_comb begin
    n = q;
    rd = 32'h0;
    bad = 1'b0;
    vis_free = 1'b0;
    cw = '0;
    // Register read decode, answered one cycle after setup
    unique case (rsel)
      RG_GLOBAL: begin
        unique case (wsel)
          GW_SGM: rd = {21'h0, q.sgm};
          GW_EGM: rd = {3'h0, q.egm};
          GW_MMATCH: rd = {16'h0, q.mmatch};
          GW_MMASK: rd = {16'h0, q.mmask};
          GW_XMASK: rd = {3'h0, q.xmask};
          GW_STATUS: begin
            rd[S_BUSY] = q.tx_busy;
            rd[S_TXC +: 4] = 4'(q.tx_idx + 4'h1);
            rd[S_SHV] = q.sh_valid;
            rd[S_LRX +: 4] = q.last_rx;
          end
          default: bad = 1'b1;
        endcase
      end
      RG_CTRL: begin
        // Center 15 shows its visible slot bits, never the shadow's
        rd = cen_ok ? {14'h0, q.ctrl[wsel]} : 32'h0; // RULE19
        bad = !cen_ok;
      end
      RG_ARB: begin
        rd = cen_ok ? {3'h0, q.arb[wsel]} : 32'h0;
        bad = !cen_ok;
      end
      RG_DLO: begin
        rd = cen_ok ? q.data[wsel][31:0] : 32'h0;
        bad = !cen_ok;
      end
      RG_DHI: begin
        rd = cen_ok ? q.data[wsel][63:32] : 32'h0;
        bad = !cen_ok;
      end
      default: bad = 1'b1;
    endcase
    if (psel && !penable) begin
      n.rdy = 1'b1;
      n.err = bad;
      n.rdata = bad ? 32'h0 : rd;
    end else if (psel && penable && q.rdy) begin
      n.rdy = 1'b0;
      n.err = 1'b0;
    end
    // Software writes land first; hardware events below override them
    if (apb_wr) begin
      unique case (rsel)
        RG_GLOBAL: begin
          unique case (wsel)
            GW_SGM: n.sgm = pwdata[10:0];
            GW_EGM: n.egm = pwdata[28:0];
            GW_MMATCH: n.mmatch = pwdata[15:0];
            GW_MMASK: n.mmask = pwdata[15:0];
            GW_XMASK: n.xmask = pwdata[28:0];
            default: n.sgm = q.sgm;
          endcase
        end
        RG_CTRL: n.ctrl[wsel] = pwdata[CW-1:0];
        RG_ARB: n.arb[wsel] = pwdata[28:0];
        RG_DLO: n.data[wsel][31:0] = pwdata;
        RG_DHI: n.data[wsel][63:32] = pwdata;
        default: n.sgm = q.sgm;
      endcase
    end
    n.ctrl[LAST][C_DIR] = 1'b0; // RULE13
    // Shadow drains only once both visible bits are clear
    if (q.sh_valid && !n.ctrl[LAST][C_DU] && !n.ctrl[LAST][C_RRS]) begin // RULE10 RULE20
      n.arb[LAST] = q.sh_id;
      n.data[LAST] = q.sh_data;
      n.ctrl[LAST][C_DLC +: 4] = q.sh_dlc;
      n.ctrl[LAST][C_DU] = !q.sh_rtr;
      n.ctrl[LAST][C_RRS] = q.sh_rtr;
      n.ctrl[LAST][C_INTF] = n.ctrl[LAST][C_INTF] | n.ctrl[LAST][C_RIE]; // RULE22
      n.sh_valid = 1'b0;
    end
    // Reception, decided and stored in the arrival cycle
    if (rx_take) begin // RULE23
      n.last_rx = 4'(rx_pick + 4'h1);
      if (rx_pick != 4'(LAST)) begin
        cw = n.ctrl[rx_pick];
        if (!cw[C_DU] || cw[C_OWA]) begin // RULE18
          cw[C_ROW] = cw[C_ROW] | cw[C_DU];
          cw[C_DU] = cw[C_DU] | !rx_rtr;
          cw[C_RRS] = cw[C_RRS] | rx_rtr;
          cw[C_DLC +: 4] = rx_dlc;
          cw[C_INTF] = cw[C_INTF] | cw[C_RIE]; // RULE22
          n.ctrl[rx_pick] = cw;
          n.arb[rx_pick] = rx_id;
          if (!rx_rtr) begin
            n.data[rx_pick] = rx_data;
          end
        end
      end else begin
        vis_free = !n.ctrl[LAST][C_DU] && !n.ctrl[LAST][C_RRS];
        if (vis_free) begin // RULE9
          n.arb[LAST] = rx_id;
          n.data[LAST] = rx_data;
          n.ctrl[LAST][C_DLC +: 4] = rx_dlc;
          n.ctrl[LAST][C_DU] = !rx_rtr;
          n.ctrl[LAST][C_RRS] = rx_rtr;
          n.ctrl[LAST][C_INTF] = n.ctrl[LAST][C_INTF] | n.ctrl[LAST][C_RIE]; // RULE22
        end else if (!n.sh_valid || n.ctrl[LAST][C_OWA]) begin // RULE11 RULE20
          n.ctrl[LAST][C_ROW] = n.ctrl[LAST][C_ROW] | n.sh_valid; // RULE19
          n.sh_valid = 1'b1;
          n.sh_rtr = rx_rtr;
          n.sh_id = rx_id;
          n.sh_dlc = rx_dlc;
          n.sh_data = rx_data;
        end
      end
    end
    // Transmit: any outcome frees the buffer, next scan starts at center 1
    if (tx_done) begin // RULE16
      n.tx_busy = 1'b0;
      if (tx_ok) begin
        n.ctrl[q.tx_idx][C_TREQ] = 1'b0; // RULE15
        n.ctrl[q.tx_idx][C_INTF] = n.ctrl[q.tx_idx][C_INTF] | q.ctrl[q.tx_idx][C_TIE]; // RULE22
      end
    end else if (!q.tx_busy && (|elig)) begin // RULE14
      n.tx_busy = 1'b1;
      n.tx_idx = tx_pick;
      n.tx_ext = q.ctrl[tx_pick][C_EXT];
      n.tx_id = q.arb[tx_pick];
      n.tx_dlc = q.ctrl[tx_pick][C_DLC +: 4];
      n.tx_data = q.data[tx_pick];
    end
  end

  assign apb_wr = psel && penable && q.rdy && pwrite && !q.err;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.egm <= MASK_RST;
      q.sgm <= MASK_RST[10:0];
      q.xmask <= MASK_RST;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.rdy;
  assign pslverr = q.err;
  assign tx_valid = q.tx_busy;
  assign tx_center = 4'(q.tx_idx + 4'h1);
  assign tx_ext = q.tx_ext;
  assign tx_id = q.tx_id;
  assign tx_dlc = q.tx_dlc;
  assign tx_data = q.tx_data;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_tx_launch;
    !q.tx_busy && (|elig) && !tx_done;
  endsequence
  sequence s_tx_loaded(logic [3:0] idx);
    q.tx_busy && (q.tx_idx == idx);
  endsequence

  AST_TX_PRIORITY: assert property (s_tx_launch |=> s_tx_loaded($past(tx_pick))) // RULE14
    else $error("transmit buffer not loaded from lowest ready center");
  AST_TX_CLEAR: assert property (q.tx_busy && tx_ok |=> !q.ctrl[$past(q.tx_idx)][C_TREQ]) // RULE15
    else $error("transmit request not cleared after successful send");
  AST_TX_RESCAN: assert property (tx_done |=> !q.tx_busy ##1 (!(|$past(elig)) || q.tx_busy)) // RULE16
    else $error("transmit scan did not restart after outcome");
  AST_RX_ERR_DROP: assert property (rx_valid && rx_error |=> $stable(q.last_rx) || q.last_rx == 4'h0) // RULE2
    else $error("errored frame was stored");
  // Judged on the stored word: the next-state copy already carries this frame's bits
  AST_RX_FIRST: assert property (rx_take && rx_pick != 4'(LAST) && !apb_wr && !q.ctrl[rx_pick][C_DU]
    |=> q.last_rx == 4'($past(rx_pick) + 4'h1) && q.arb[$past(rx_pick)] == $past(rx_id)) // RULE1
    else $error("frame not stored in first accepting center");
  AST_NO_TX15: assert property (q.tx_busy |-> q.tx_idx != 4'(LAST)) // RULE13
    else $error("receive-only center selected for transmit");
  AST_SHADOW_MOVE: assert property ($fell(q.sh_valid) |-> q.ctrl[LAST][C_DU] || q.ctrl[LAST][C_RRS]) // RULE10
    else $error("shadow left without filling visible slot");
  AST_ROW15: assert property ($rose(q.ctrl[LAST][C_ROW]) |-> $past(q.sh_valid) && $past(q.ctrl[LAST][C_OWA])) // RULE19
    else $error("center 15 overrun without shadow overwrite");
  AST_APB_ANSWER: assert property (psel && !penable ##1 psel && penable |-> pready)
    else $error("APB access not answered in first access cycle");
endmodule

/* src/cmcf_pkg.sv */
package cmcf_pkg;
  localparam int unsigned NUM_CENTERS = 15;
  localparam int unsigned LAST = 14;
  // Control word field positions
  localparam int unsigned C_VALID = 0;
  localparam int unsigned C_DIR = 1;
  localparam int unsigned C_HOLD = 2;
  localparam int unsigned C_DU = 3;
  localparam int unsigned C_TREQ = 4;
  localparam int unsigned C_RRS = 5;
  localparam int unsigned C_INTF = 6;
  localparam int unsigned C_OWA = 7;
  localparam int unsigned C_RIE = 8;
  localparam int unsigned C_TIE = 9;
  localparam int unsigned C_ROW = 10;
  localparam int unsigned C_EXT = 11;
  localparam int unsigned C_IMU = 12;
  localparam int unsigned C_MMU = 13;
  localparam int unsigned C_DLC = 14;
  localparam int unsigned CW = 18;
  // Address regions, paddr[11:6]
  localparam logic [5:0] RG_GLOBAL = 6'h00;
  localparam logic [5:0] RG_CTRL = 6'h01;
  localparam logic [5:0] RG_ARB = 6'h02;
  localparam logic [5:0] RG_DLO = 6'h03;
  localparam logic [5:0] RG_DHI = 6'h04;
  // Global words, paddr[5:2]
  localparam logic [3:0] GW_SGM = 4'h0;
  localparam logic [3:0] GW_EGM = 4'h1;
  localparam logic [3:0] GW_MMATCH = 4'h2;
  localparam logic [3:0] GW_MMASK = 4'h3;
  localparam logic [3:0] GW_XMASK = 4'h4;
  localparam logic [3:0] GW_STATUS = 4'h5;
  // Status word layout
  localparam int unsigned S_BUSY = 0;
  localparam int unsigned S_TXC = 4;
  localparam int unsigned S_SHV = 8;
  localparam int unsigned S_LRX = 12;
  // Reset values
  localparam logic [CW-1:0] CTRL_RST = 18'h00000;
  localparam logic [28:0] MASK_RST = 29'h1fffffff;
endpackage
